// ==== hw/rcis_pkg.sv ====
// rcis_pkg: register map, field layout, reset values and state record of
// the reset-cause register and interrupt-source block.
// assumes: a 32-bit APB slave on pclk with byte addresses as below.
// Functional notes
// (R1) bit 7 enables two priority levels when 1, single level when 0; resets 0.
// (R2) software brown-out bit works only when config field is 01, else reads 0.
// (R3) software brown-out bit resets to 1 when config allows it, else 0.
// (R4) reset-instruction flag bit 4 cleared by reset instruction, otherwise 1.
// (R5) watchdog flag bit 3 set by power-up, clear or sleep; cleared by timeout.
// (R6) sleep flag bit 2 set by power-up or watchdog clear; cleared by sleep.
// (R7) power-on flag bit 1 cleared on power-on reset; software writes it to 1.
// (R8) brown-out flag bit 0 cleared on brown-out reset; only firmware sets it.
// (R9) bit 5 of the reset-cause register always reads zero.
// (R10) three external pins are edge triggered; select 1 rising, 0 falling.
// (R11) selected edge sets the pin flag; enable bit low blocks the request.
// (R12) software clears a pin flag before enabling that interrupt again.
// (R13) enabled external pin interrupt wakes processor from idle or sleep.
// (R14) after wake, vector taken only when global enable set; else resume.
// (R15) pins 1 and 2 have priority bits; pin 0 is always high priority.
// (R16) timer flag set on wrap FFh to 00h, or FFFFh to 0000h in 16-bit mode.
// (R17) timer interrupt gated by its enable; priority bit in second control.
// (R18) enabled port A/B pin change sets shared flag; common enable, priority.
// (R19) on entry push return address; save working, status and bank registers.
// (R20) with single level, software sets peripheral enable for peripherals; the single-level request ignores peripheral enable.
// (R21) request raised only when flag, enable and global enable all set.
// (R22) source flag stays set until software clears it.
package rcis_pkg;
    localparam logic [7:0] RCIS_OFS_RCC  = 8'h00;
    localparam logic [7:0] RCIS_OFS_MAIN = 8'h04;
    localparam logic [7:0] RCIS_OFS_SEC  = 8'h08;
    localparam logic [7:0] RCIS_OFS_THRD = 8'h0c;
    localparam logic [7:0] RCIS_OFS_IOC  = 8'h10;
    localparam logic [7:0] RCIS_OFS_TMR  = 8'h14;
    localparam logic [7:0] RCIS_OFS_CTX  = 8'h18;

    localparam int RCC_PRIORITY_LEVELS_ENABLE = 7;
    localparam int RCC_SBOR = 6;
    localparam int RCC_RI   = 4;
    localparam int RCC_TO   = 3;
    localparam int RCC_PD   = 2;
    localparam int RCC_POR  = 1;
    localparam int RCC_BOR  = 0;

    localparam logic RCC_PRIORITY_LEVELS_ENABLE_RST = 1'b0;
    localparam logic RCC_RI_RST   = 1'b1;
    localparam logic RCC_TO_RST   = 1'b1;
    localparam logic RCC_PD_RST   = 1'b1;
    localparam logic RCC_POR_RST  = 1'b0;
    localparam logic RCC_BOR_RST  = 1'b0;

    localparam logic [1:0] RCIS_BOR_SW = 2'h1;
    localparam int         RCIS_PC_W   = 21;

    typedef struct packed {
        logic [RCIS_PC_W-1:0] pc;
        logic [7:0]           working_register;
        logic [7:0]           status;
        logic [7:0]           bank_select_register;
    } rcis_ctx_t;

    typedef struct packed {
        logic        init;
        logic        priority_levels_enable, software_brownout_enable, ri, wto, pd, por, bor;
        logic        global_irq_enable, peripheral_irq_enable, t0_en, pc_en;
        logic [2:0]  ext_en, ext_flag, ext_edge;
        logic        t0_flag, pc_flag, t0_pri, pc_pri, t0_16;
        logic [2:1]  ext_pri;
        logic [15:0] ioc_en, port_latch;
        logic [2:0]  ext_s1, ext_s2, ext_prev;
        logic [15:0] port_s1, port_s2, tcnt_prev;
        rcis_ctx_t   ctx;
        logic        push;
        logic [31:0] prdata;
    } rcis_state_t;

    localparam rcis_state_t RCIS_STATE_RST = '{
        init: 1'b0, priority_levels_enable: RCC_PRIORITY_LEVELS_ENABLE_RST, software_brownout_enable: 1'b0, ri: RCC_RI_RST,
        wto: RCC_TO_RST, pd: RCC_PD_RST, por: RCC_POR_RST,
        bor: RCC_BOR_RST, default: '0};
endpackage : rcis_pkg

// ==== hw/rcis_top.sv ====
// rcis_top: reset-cause register, external pin, timer wrap and port change
// interrupt sources, priority split and context capture on entry.
// assumes: core events and timer count are on pclk; pins are asynchronous;
// brownout_config_field is static configuration.
`timescale 1ns/1ps
`default_nettype none
module rcis_top
    import rcis_pkg::*;
(
    input  wire logic        pclk,                  // system clock
    input  wire logic        presetn,               // async reset, low
    input  wire logic        psel,                  // apb select
    input  wire logic        penable,               // apb access phase
    input  wire logic        pwrite,                // apb direction
    input  wire logic [7:0]  paddr,                 // apb byte address
    input  wire logic [31:0] pwdata,                // apb write data
    input  wire logic [3:0]  pstrb,                 // apb byte strobes
    output logic      [31:0] prdata,                // apb read data
    output logic             pready,                // apb ready
    output logic             pslverr,               // apb error
    input  wire logic [1:0]  brownout_config_field, // brown-out config
    input  wire logic        por_event,             // power-on reset seen
    input  wire logic        bor_event,             // brown-out reset seen
    input  wire logic        reset_instr_event,     // reset instruction
    input  wire logic        wdt_timeout_event,     // watchdog timeout
    input  wire logic        wdt_clear_event,       // watchdog clear instr
    input  wire logic        sleep_event,           // sleep instruction
    input  wire logic [2:0]  ext_pin,               // external irq pins
    input  wire logic [7:0]  port_a_pins,           // port a inputs
    input  wire logic [7:0]  port_b_pins,           // port b inputs
    input  wire logic        port_read_strobe,      // port a/b access
    input  wire logic [15:0] timer_zero_count,      // high:low count
    input  wire logic        core_irq_ack,          // interrupt entry
    input  wire rcis_ctx_t   core_ctx,              // live core context
    output logic             irq_high,              // high level request
    output logic             irq_low,               // low level request
    output logic             wake_req,              // wake from sleep
    output logic             bor_sw_enable,         // brown-out detect on
    output logic             stack_push,            // return stack push
    output rcis_ctx_t        saved_ctx              // pushed/saved context
);
    rcis_state_t q;
    rcis_state_t d;
    logic [2:0]  ext_hit;
    logic [15:0] mismatch;
    logic        t0_wrap;
    logic        sw_bor;
    logic        setup_rd;
    logic        acc_wr;
    logic        mapped;
    logic [4:0]  pend;
    logic [4:0]  pri_hi;
    logic        any_hi;
    logic        any_lo;

    // hardware set beats a software clear landing in the same cycle
    function automatic logic sticky(input logic cur, input logic set,
                                    input logic wr, input logic wbit);
        return set | (wr ? wbit : cur);
    endfunction : sticky

    function automatic logic hit(input logic wr, input logic [7:0] a,
                                 input logic [7:0] ofs);
        return wr && (a == ofs);
    endfunction : hit

    // edge detection on synchronised pins only
    assign ext_hit = (q.ext_edge & q.ext_s2 & ~q.ext_prev)
                   | (~q.ext_edge & ~q.ext_s2 & q.ext_prev); // R10
    // mismatch keeps setting the flag until a port access relatches
    assign mismatch = (q.port_s2 ^ q.port_latch) & q.ioc_en; // R18
    assign t0_wrap = q.t0_16 ?
        (q.tcnt_prev == 16'hffff && timer_zero_count == 16'h0000) :
        (q.tcnt_prev[7:0] == 8'hff && timer_zero_count[7:0] == 8'h00);
    assign sw_bor = (brownout_config_field == RCIS_BOR_SW);
    assign setup_rd = psel && !penable && !pwrite;
    assign acc_wr = psel && penable && pwrite;
    assign mapped = (paddr <= RCIS_OFS_CTX) && (paddr[1:0] == 2'h0);

    // order: ext0, ext1, ext2, timer, port change
    assign pend = {q.pc_flag & q.pc_en, q.t0_flag & q.t0_en,
                   q.ext_flag & q.ext_en}; // R11 R17 R18
    assign pri_hi = {q.pc_pri, q.t0_pri, q.ext_pri, 1'b1}; // R15 R17
    assign any_hi = |(pend & pri_hi);
    assign any_lo = |(pend & ~pri_hi);

    always_comb begin
        // single level: all sources share one request behind the global gate
        if (!q.priority_levels_enable) begin
            irq_high = (|pend) && q.global_irq_enable; // R1 R21
            irq_low = 1'b0;
        end else begin
            irq_high = any_hi && q.global_irq_enable; // R21
            irq_low = any_lo && q.global_irq_enable && q.peripheral_irq_enable; // R21
        end
    end

    // wake ignores the global gate; the vector then follows irq_* only
    assign wake_req = |pend; // R13 R14
    assign bor_sw_enable = sw_bor && q.software_brownout_enable; // R2
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = q.prdata;
    assign stack_push = q.push;
    assign saved_ctx = q.ctx;

    always_comb begin
        d = q;
        d.ext_s1 = ext_pin;
        d.ext_s2 = q.ext_s1;
        d.ext_prev = q.ext_s2;
        d.port_s1 = {port_b_pins, port_a_pins};
        d.port_s2 = q.port_s1;
        d.tcnt_prev = timer_zero_count;
        d.push = 1'b0;

        // configuration caught on the first edge after reset release
        if (!q.init) begin
            d.init = 1'b1;
            d.software_brownout_enable = sw_bor; // R3
        end

        if (hit(acc_wr, paddr, RCIS_OFS_RCC) && pstrb[0]) begin
            d.priority_levels_enable = pwdata[RCC_PRIORITY_LEVELS_ENABLE]; // R1
            if (sw_bor) begin
                d.software_brownout_enable = pwdata[RCC_SBOR]; // R2
            end
            d.ri = pwdata[RCC_RI];
            d.por = pwdata[RCC_POR]; // R7
            d.bor = pwdata[RCC_BOR]; // R8
        end
        if (hit(acc_wr, paddr, RCIS_OFS_MAIN) && pstrb[0]) begin
            d.global_irq_enable = pwdata[7];
            d.peripheral_irq_enable = pwdata[6];
            d.t0_en = pwdata[5];
            d.ext_en[0] = pwdata[4];
            d.pc_en = pwdata[3];
        end
        if (hit(acc_wr, paddr, RCIS_OFS_SEC) && pstrb[0]) begin
            d.ext_edge = pwdata[6:4]; // R10
            d.t0_pri = pwdata[2]; // R17
            d.pc_pri = pwdata[0]; // R18
        end
        if (hit(acc_wr, paddr, RCIS_OFS_THRD) && pstrb[0]) begin
            d.ext_pri = pwdata[7:6]; // R15
            d.ext_en[2:1] = pwdata[4:3];
        end
        if (hit(acc_wr, paddr, RCIS_OFS_IOC)) begin
            if (pstrb[0]) begin
                d.ioc_en[7:0] = pwdata[7:0];
            end
            if (pstrb[1]) begin
                d.ioc_en[15:8] = pwdata[15:8];
            end
        end
        if (hit(acc_wr, paddr, RCIS_OFS_TMR) && pstrb[0]) begin
            d.t0_16 = pwdata[0]; // R16
        end

        // hardware reset-cause events override a same-cycle write
        if (por_event) begin
            d.por = 1'b0; // R7
        end
        if (bor_event) begin
            d.bor = 1'b0; // R8
        end
        if (reset_instr_event) begin
            d.ri = 1'b0; // R4
        end
        if (por_event || wdt_clear_event) begin
            d.wto = 1'b1; // R5
            d.pd = 1'b1; // R6
        end
        if (sleep_event) begin
            d.wto = 1'b1; // R5
            d.pd = 1'b0; // R6
        end
        if (wdt_timeout_event) begin
            d.wto = 1'b0; // R5
        end

        d.ext_flag[0] = sticky(q.ext_flag[0], ext_hit[0],
            hit(acc_wr, paddr, RCIS_OFS_MAIN) && pstrb[0],
            pwdata[1]); // R11 R22
        d.ext_flag[2:1] = {
            sticky(q.ext_flag[2], ext_hit[2],
                hit(acc_wr, paddr, RCIS_OFS_THRD) && pstrb[0], pwdata[1]),
            sticky(q.ext_flag[1], ext_hit[1],
                hit(acc_wr, paddr, RCIS_OFS_THRD) && pstrb[0], pwdata[0])
        }; // R11 R22
        d.t0_flag = sticky(q.t0_flag, t0_wrap,
            hit(acc_wr, paddr, RCIS_OFS_MAIN) && pstrb[0],
            pwdata[2]); // R16 R22
        d.pc_flag = sticky(q.pc_flag, |mismatch,
            hit(acc_wr, paddr, RCIS_OFS_MAIN) && pstrb[0],
            pwdata[0]); // R18 R22
        if (port_read_strobe) begin
            d.port_latch = q.port_s2;
        end

        if (core_irq_ack) begin
            d.ctx = core_ctx; // R19
            d.push = 1'b1; // R19
        end

        // read data is registered in setup so access completes at once
        if (setup_rd) begin
            case (paddr)
                RCIS_OFS_RCC:  d.prdata = {24'h000000, q.priority_levels_enable,
                    q.software_brownout_enable & sw_bor, 1'b0, q.ri, q.wto, q.pd,
                    q.por, q.bor}; // R2 R9
                RCIS_OFS_MAIN: d.prdata = {24'h000000, q.global_irq_enable, q.peripheral_irq_enable,
                    q.t0_en, q.ext_en[0], q.pc_en, q.t0_flag,
                    q.ext_flag[0], q.pc_flag};
                RCIS_OFS_SEC:  d.prdata = {24'h000000, 1'b0, q.ext_edge,
                    1'b0, q.t0_pri, 1'b0, q.pc_pri};
                RCIS_OFS_THRD: d.prdata = {24'h000000, q.ext_pri, 1'b0,
                    q.ext_en[2:1], 1'b0, q.ext_flag[2:1]};
                RCIS_OFS_IOC:  d.prdata = {16'h0000, q.ioc_en};
                RCIS_OFS_TMR:  d.prdata = {31'h00000000, q.t0_16};
                RCIS_OFS_CTX:  d.prdata = {8'h00, q.ctx.bank_select_register,
                    q.ctx.status, q.ctx.working_register};
                default:       d.prdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= RCIS_STATE_RST;
        end else begin
            q <= d;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_rcc_read;
        setup_rd && paddr == RCIS_OFS_RCC;
    endsequence

    // a timeout in the same cycle legally clears the watchdog flag
    sequence s_sleep_then_clear;
        sleep_event && !wdt_clear_event && !por_event
            && !wdt_timeout_event ##1 1'b1;
    endsequence

    // two steps: synchronised rise seen, flag one edge later
    sequence s_pin1_rise;
        q.ext_edge[1] && q.ext_s2[1] && !q.ext_prev[1];
    endsequence

    a_priority_levels_enable_single: assert property (!q.priority_levels_enable |-> !irq_low) // R1
        else $error("low request while priority levels off");

    a_sbor_inert: assert property ((s_rcc_read and !sw_bor)
        |=> !prdata[RCC_SBOR] && !bor_sw_enable) // R2
        else $error("brown-out enable not inert");

    a_sbor_load: assert property (!q.init && !acc_wr
        |=> q.software_brownout_enable == $past(sw_bor)) // R3
        else $error("brown-out enable reset value wrong");

    a_bit5_zero: assert property (s_rcc_read |=> !prdata[5]) // R9
        else $error("reserved bit reads one");

    a_ri_clear: assert property (reset_instr_event |=> !q.ri) // R4
        else $error("reset-instruction flag not cleared");

    a_ri_hold: assert property (q.ri && !reset_instr_event && !acc_wr
        |=> q.ri) // R4
        else $error("reset-instruction flag dropped");

    a_wto_clear: assert property (wdt_timeout_event |=> !q.wto) // R5
        else $error("watchdog flag not cleared on timeout");

    a_wto_set: assert property ((por_event || wdt_clear_event
        || sleep_event) && !wdt_timeout_event |=> q.wto) // R5
        else $error("watchdog flag not set");

    a_pd_sleep: assert property (s_sleep_then_clear
        |-> !q.pd && q.wto) // R6
        else $error("sleep flag wrong after sleep");

    a_pd_set: assert property ((por_event || wdt_clear_event)
        && !sleep_event |=> q.pd) // R6
        else $error("sleep flag not set");

    a_por_clear: assert property (por_event && !sleep_event
        |=> !q.por && q.pd) // R7
        else $error("power-on flag not cleared");

    a_bor_clear: assert property (bor_event |=> !q.bor) // R8
        else $error("brown-out flag not cleared");

    a_bor_hw_set: assert property (!q.bor && !acc_wr |=> !q.bor) // R8
        else $error("brown-out flag set by hardware");

    a_edge_sel: assert property (s_pin1_rise |=> q.ext_flag[1]) // R10
        else $error("rising edge select ignored");

    a_ext_edge: assert property (ext_hit[1] |=> q.ext_flag[1]) // R11
        else $error("pin edge lost");

    a_ext0_edge: assert property (ext_hit[0] |=> q.ext_flag[0]) // R11
        else $error("pin zero edge lost");

    a_ext2_edge: assert property (ext_hit[2] |=> q.ext_flag[2]) // R11
        else $error("pin two edge lost");

    a_idle_quiet: assert property (pend == 5'h00
        |-> !wake_req && !irq_high && !irq_low) // R11 R21
        else $error("request without enabled flag");

    a_wake_pend: assert property ((|pend) |-> wake_req) // R13
        else $error("enabled source gives no wake");

    a_ext0_high: assert property (q.priority_levels_enable && q.global_irq_enable && q.ext_en[0]
        && q.ext_flag[0] |-> irq_high) // R15
        else $error("pin zero not high priority");

    a_t0_wrap: assert property (!q.t0_16 && q.tcnt_prev[7:0] == 8'hff
        && timer_zero_count[7:0] == 8'h00 |=> q.t0_flag) // R16
        else $error("timer wrap missed");

    a_t0_wrap16: assert property (q.t0_16 && q.tcnt_prev == 16'hffff
        && timer_zero_count == 16'h0000 |=> q.t0_flag) // R16
        else $error("16-bit timer wrap missed");

    a_pc_set: assert property ((|mismatch) |=> q.pc_flag) // R18
        else $error("port change missed");

    a_pc_hold: assert property (q.pc_flag
        && !hit(acc_wr, paddr, RCIS_OFS_MAIN) |=> q.pc_flag) // R22
        else $error("change flag dropped without clear");

    a_ext_hold: assert property (q.ext_flag[0] && !acc_wr
        |=> q.ext_flag[0]) // R22
        else $error("pin flag dropped without clear");

    a_gate_req: assert property (!q.global_irq_enable |-> !irq_high && !irq_low) // R21
        else $error("request without global enable");

    a_low_gate: assert property (irq_low |-> q.global_irq_enable && q.peripheral_irq_enable) // R21
        else $error("low request without both enables");

    a_push_cause: assert property (stack_push
        |-> $past(core_irq_ack)) // R19
        else $error("push without interrupt entry");

    a_ctx_save: assert property (core_irq_ack
        |=> stack_push && saved_ctx == $past(core_ctx)
        ##1 !stack_push || $past(core_irq_ack)) // R19
        else $error("context not saved on entry");
endmodule : rcis_top
`default_nettype wire

// ==== testbench/rcis_far_model.sv ====
// rcis_far_model: core and pin side of the interrupt-source block.
// assumes: every change lands by nba just after a rising pclk edge.
`timescale 1ns/1ps
`default_nettype none
module rcis_far_model
    import rcis_pkg::*;
(
    input  wire logic  pclk,   // system clock
    output logic [5:0] ev,     // por,bor,ri,timeout,clear,sleep
    output logic [2:0] pin,    // external irq pins
    output logic [15:0] port,  // port b:a pins
    output logic       strobe, // port read strobe
    output logic [15:0] tcount, // timer high:low
    output logic       ack,    // interrupt entry
    output rcis_ctx_t  ctx     // live core context
);
    initial begin
        {ev, pin, port, strobe, tcount, ack, ctx} = '0;
    end

    // one-cycle core event pulse
    task automatic pulse(input int i);
        @(posedge pclk) ev[i] <= 1'b1;
        @(posedge pclk) ev[i] <= 1'b0;
    endtask : pulse

    // context moves on after entry, so a late capture is seen
    task automatic enter(input rcis_ctx_t c);
        @(posedge pclk);
        ack <= 1'b1;
        ctx <= c;
        @(posedge pclk);
        ack <= 1'b0;
        ctx <= ~c;
    endtask : enter
endmodule : rcis_far_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
// tb_top: register, event, edge, priority, timer, port change and context.
// assumes: zero-wait apb slave; far model drives the core side.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import rcis_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        perr, strobe, ack, irq_high, irq_low, wake_req;
    logic        bor_sw_enable, stack_push;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0]  cfg;
    logic [5:0]  ev;
    logic [2:0]  pin;
    logic [15:0] port, tcount;
    rcis_ctx_t   ctx, saved_ctx;
    int          mismatches = 0;
    int          checks_done = 0;
    int          ev_i[6] = '{3, 5, 4, 2, 0, 1};
    logic [7:0]  ev_e[6] = '{8'h17, 8'h1b, 8'h1f, 8'h0f, 8'h0d, 8'h0c};
    logic [7:0]  pr_m[5] = '{8'h92, 8'h80, 8'hc0, 8'hc0, 8'h40};
    logic [7:0]  pr_t[5] = '{8'h00, 8'h09, 8'h09, 8'h49, 8'h49};
    logic [2:0]  pr_e[5] = '{3'h5, 3'h1, 3'h3, 3'h5, 3'h1};
    logic [15:0] tm_f[4] = '{16'h00ff, 16'h00ff, 16'hffff, 16'h0010};
    logic        tm_m[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    logic        tm_x[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    rcis_ctx_t   cx = '{pc: 21'h1abcd, working_register: 8'h5a, status: 8'hc3,
                        bank_select_register: 8'h0e};
    logic [31:0] r;

    rcis_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .brownout_config_field(cfg), .por_event(ev[0]), .bor_event(ev[1]),
        .reset_instr_event(ev[2]), .wdt_timeout_event(ev[3]),
        .wdt_clear_event(ev[4]), .sleep_event(ev[5]), .ext_pin(pin),
        .port_a_pins(port[7:0]), .port_b_pins(port[15:8]),
        .port_read_strobe(strobe), .timer_zero_count(tcount),
        .core_irq_ack(ack), .core_ctx(ctx), .irq_high(irq_high),
        .irq_low(irq_low), .wake_req(wake_req),
        .bor_sw_enable(bor_sw_enable), .stack_push(stack_push),
        .saved_ctx(saved_ctx));

    rcis_far_model far_u (.pclk(pclk), .ev(ev), .pin(pin), .port(port),
        .strobe(strobe), .tcount(tcount), .ack(ack), .ctx(ctx));

    task automatic stop_test();
        if (mismatches == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [63:0] e,
                       input logic [63:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        perr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
        apb(1'b0, a, '0, r);
        chk(nm, 64'(e), 64'(r));
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, r);
    endtask : wr

    task automatic rd_bit(input int i, input logic e, input string nm);
        apb(1'b0, (i == 0) ? RCIS_OFS_MAIN : RCIS_OFS_THRD, '0, r);
        chk(nm, 64'(e), 64'(r[(i == 0) ? 1 : i - 1]));
    endtask : rd_bit

    // sampled mid-cycle so outputs decoded from registered state have settled
    task automatic outs(input logic h, input logic l, input logic w,
                        input string nm);
        @(negedge pclk);
        chk(nm, {61'b0, h, l, w}, {61'b0, irq_high, irq_low, wake_req});
    endtask : outs

    task automatic do_reset(input logic [1:0] c);
        presetn <= 1'b0;
        cfg     <= c;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask : do_reset

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        #500000;
        mismatches++;
        stop_test();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        do_reset(2'h1);
        rd(RCIS_OFS_RCC, 32'h5c, "rcc reset");
        wr(RCIS_OFS_RCC, 32'hff);
        rd(RCIS_OFS_RCC, 32'hdf, "rcc ones");
        chk("bor enable on", 64'h1, 64'(bor_sw_enable));
        wr(RCIS_OFS_RCC, 32'h13);
        @(negedge pclk);
        chk("bor enable off", 64'h0, 64'(bor_sw_enable));
        for (int k = 0; k < 6; k++) begin
            far_u.pulse(ev_i[k]);
            rd(RCIS_OFS_RCC, 32'(ev_e[k]), "rcc event");
        end
        for (int i = 0; i < 3; i++) begin
            for (int s = 0; s < 2; s++) begin
                wr(RCIS_OFS_SEC, 32'(s) << (4 + i));
                wr(RCIS_OFS_MAIN, (i == 0 && s == 1) ? 32'h90 : 32'h80);
                wr(RCIS_OFS_THRD, (s == 1 && i > 0) ? 32'h4 << i : 32'h0);
                @(posedge pclk) far_u.pin[i] <= ~1'(s);
                repeat (5) @(posedge pclk);
                rd_bit(i, 1'b0, "ext wrong edge");
                @(posedge pclk) far_u.pin[i] <= 1'(s);
                repeat (5) @(posedge pclk);
                rd_bit(i, 1'b1, "ext flag");
                outs(1'(s), 1'b0, 1'(s), "ext request");
                @(posedge pclk) far_u.pin[i] <= ~1'(s);
                repeat (5) @(posedge pclk);
                rd_bit(i, 1'b1, "ext sticky");
            end
        end
        wr(RCIS_OFS_RCC, 32'h80);
        for (int k = 0; k < 5; k++) begin
            wr(RCIS_OFS_MAIN, 32'(pr_m[k]));
            wr(RCIS_OFS_THRD, 32'(pr_t[k]));
            outs(pr_e[k][2], pr_e[k][1], pr_e[k][0], "priority");
        end
        wr(RCIS_OFS_RCC, 32'h00);
        wr(RCIS_OFS_THRD, 32'h0);
        for (int k = 0; k < 4; k++) begin
            wr(RCIS_OFS_TMR, 32'(tm_m[k]));
            wr(RCIS_OFS_MAIN, 32'ha0);
            @(posedge pclk) far_u.tcount <= tm_f[k];
            repeat (2) @(posedge pclk);
            @(posedge pclk) far_u.tcount <= tm_f[k] + 16'h1;
            repeat (3) @(posedge pclk);
            outs(tm_x[k], 1'b0, tm_x[k], "timer wrap");
        end
        wr(RCIS_OFS_IOC, 32'h1);
        wr(RCIS_OFS_MAIN, 32'h88);
        @(posedge pclk) far_u.port[8] <= 1'b1;
        repeat (5) @(posedge pclk);
        outs(1'b0, 1'b0, 1'b0, "port masked");
        @(posedge pclk) far_u.port[0] <= 1'b1;
        repeat (5) @(posedge pclk);
        outs(1'b1, 1'b0, 1'b1, "port change");
        @(posedge pclk) far_u.strobe <= 1'b1;
        @(posedge pclk) far_u.strobe <= 1'b0;
        repeat (4) @(posedge pclk);
        wr(RCIS_OFS_MAIN, 32'h88);
        outs(1'b0, 1'b0, 1'b0, "port cleared");
        far_u.enter(cx);
        @(negedge pclk);
        chk("stack push", 64'h1, 64'(stack_push));
        chk("saved ctx", 64'(cx), 64'(saved_ctx));
        @(negedge pclk);
        chk("push length", 64'h0, 64'(stack_push));
        wr(RCIS_OFS_CTX, 32'hffffffff);
        rd(RCIS_OFS_CTX, 32'h000ec35a, "ctx regs");
        rd(8'h1c, 32'h0, "unmapped data");
        chk("unmapped error", 64'h1, 64'(perr));
        do_reset(2'h0);
        rd(RCIS_OFS_RCC, 32'h1c, "rcc reset cfg");
        wr(RCIS_OFS_RCC, 32'h40);
        rd(RCIS_OFS_RCC, 32'h0c, "bor bit inert");
        chk("bor enable inert", 64'h0, 64'(bor_sw_enable));
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
